/* File: lgs_regs.svh */
// Register offsets, field positions and timing figures of the safety output controller
`ifndef LGS_REGS_SVH
`define LGS_REGS_SVH

// ==========================================================================
// Register map
`define LGS_ADDR_CTRL      8'h00
`define LGS_ADDR_STATUS    8'h04
`define LGS_ADDR_CONFIG    8'h08
`define LGS_CTRL_ERR_CLR   0
`define LGS_CTRL_TEST      1
`define LGS_RESP_OKAY      2'h0
`define LGS_RESP_SLVERR    2'h2

// ==========================================================================
// Switch pair roles and error vector
`define LGS_SW_TIMEOUT     0
`define LGS_SW_MUTING      1
`define LGS_SW_FEEDBACK    2
`define LGS_SW_RESTART     3
`define LGS_ERR_W          5

// ==========================================================================
// Timing figures as printed, and derived counts
`define LGS_CLK_HZ         100000000
`define LGS_MS_PER_S       1000
`define LGS_T_MUTE_MIN     10
`define LGS_T_PAIR_S       4
`define LGS_T_START_DS     5
`define LGS_T_FB_OPEN_MS   350
`define LGS_T_FB_CLOSE_MS  100
`define LGS_CNT_MS_DIV     (`LGS_CLK_HZ / `LGS_MS_PER_S)
`define LGS_CNT_MUTE_MS    (`LGS_T_MUTE_MIN * 60 * `LGS_MS_PER_S)
`define LGS_CNT_PAIR_MS    (`LGS_T_PAIR_S * `LGS_MS_PER_S)
`define LGS_CNT_START_MS   (`LGS_T_START_DS * `LGS_MS_PER_S / 10)
`define LGS_DIV_W          17
`define LGS_TMR_W          20

`endif

/* File: lgs_pkg.sv */
// Types shared by the safety output controller
`default_nettype none
package lgs_pkg;

    // Main operating states, one-hot
    typedef enum logic [3:0] {
        LGS_ST_RUN  = 4'h1,
        LGS_ST_TRIP = 4'h2,
        LGS_ST_ARM  = 4'h4,
        LGS_ST_SAFE = 4'h8
    } lgs_state_t;

endpackage
`default_nettype wire

/* File: lgs_tmr_if.sv */
// Control and expiry signals between the controller and one window timer
`timescale 1ns/1ps
`default_nettype none
`include "lgs_regs.svh"
interface lgs_tmr_if;
    logic                  run;
    logic                  tick;
    logic [`LGS_TMR_W-1:0] limit;
    logic                  expired;
    modport ctl (output run, output tick, output limit, input expired);
    modport tmr (input run, input tick, input limit, output expired);
endinterface
`default_nettype wire

/* File: lgs_timer.sv */
// Millisecond window timer, cleared whenever it is not running
`timescale 1ns/1ps
`default_nettype none
`include "lgs_regs.svh"
module lgs_timer (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    lgs_tmr_if.tmr    tif
);
    logic [`LGS_TMR_W-1:0] cnt_reg;
    logic [`LGS_TMR_W-1:0] cnt_next;

    // ======================================================================
    // Count ticks up to the limit, then hold
    assign tif.expired = tif.run && (cnt_reg >= tif.limit);
    assign cnt_next    = !tif.run ? '0 :
                         (tif.tick && !tif.expired) ? cnt_reg + `LGS_TMR_W'(1) : cnt_reg;

    // Counter register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // lgs_timer
`default_nettype wire

/* File: lgs_safety_ctrl.sv */
// Safety output controller: trip, restart, feedback check, muting, AXI4-Lite registers
// Summary of operation
// - Beam interruption switches safety outputs off immediately
// - All switches on: 10 min, 4-beam, no feedback, auto
// - Feedback pair both on disables feedback monitoring
// - Restart pair both on selects automatic restart
// - Automatic mode restarts once field is clear
// - Interlock restart needs start held 0.5 s, field clear
// - Internal error locks outputs off until explicit reset
// - Output, optic, lamp, feedback faults are internal errors
// - Feedback must open within 350 ms after on
// - Feedback must close within 100 ms after off
// - Feedback checked on every trip and before restart
// - Active muting keeps outputs on despite interruptions
// - Second muting sensor within 4 s of first
// - Muting timeout with sensors active cancels muting, trips
// - No muting entry while tripped with field interrupted
`timescale 1ns/1ps
`default_nettype none
`include "lgs_regs.svh"
module lgs_safety_ctrl #(
    parameter int unsigned MS_DIV     = `LGS_CNT_MS_DIV,
    parameter int unsigned MUTE_TO_MS = `LGS_CNT_MUTE_MS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        beam_clear_in,
    input  wire logic        start_btn_in,
    input  wire logic        fb_closed_in,
    input  wire logic        mute_s1_in,
    input  wire logic        mute_s2_in,
    input  wire logic        fault_output_in,
    input  wire logic        fault_optic_in,
    input  wire logic        fault_lamp_in,
    input  wire logic [7:0]  config_switch_pairs,
    output logic [1:0]       safety_output_pair,
    output logic             muting_lamp,
    output logic             safe_state
);
    // ======================================================================
    // Declarations
    logic [15:0]            sync1_reg;
    logic [15:0]            sync2_reg;
    logic [7:0]             cfg_sw;
    logic [3:0]             cfg_lo;
    logic [3:0]             cfg_hi;
    logic                   beam_clear;
    logic                   start_btn;
    logic                   fb_closed;
    logic                   mute_s1;
    logic                   mute_s2;
    logic                   f_out;
    logic                   f_opt;
    logic                   f_lamp;
    logic                   cfg_ok;
    logic                   to_en;
    logic                   four_beam;
    logic                   mon_en;
    logic                   auto_rst;
    logic                   fb_ok;
    logic                   beam_int;
    logic                   trip;
    logic                   out_on;
    logic [`LGS_DIV_W-1:0]  ms_cnt_reg;
    logic                   ms_tick_reg;
    logic                   ms_wrap;
    lgs_pkg::lgs_state_t    st_reg;
    lgs_pkg::lgs_state_t    st_next;
    logic [`LGS_ERR_W-1:0]  err_reg;
    logic [`LGS_ERR_W-1:0]  err_set;
    logic [`LGS_ERR_W-1:0]  err_next;
    logic                   err_any;
    logic                   err_clr;
    logic                   test_reg;
    logic                   fb_err;
    logic                   start_done;
    logic                   mute_to_exp;
    logic                   pair_exp;
    logic                   mute_reg;
    logic                   mute_next;
    logic                   mute_go;
    logic                   mute_blk_reg;
    logic                   first_s2_reg;
    logic                   s_none;
    logic                   s_both;
    logic                   s_one;
    logic                   aw_got_reg;
    logic                   w_got_reg;
    logic [7:0]             awaddr_reg;
    logic [31:0]            wdata_reg;
    logic [3:0]             wstrb_reg;
    logic                   aw_take;
    logic                   w_take;
    logic                   ar_take;
    logic                   wr_go;
    logic [7:0]             wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;
    logic                   wr_ctrl;
    logic                   aw_got_next;
    logic                   w_got_next;
    logic                   bvalid_next;
    logic                   rvalid_next;
    logic [31:0]            rd_word;
    logic                   rd_hit;

    lgs_tmr_if tmr[4] ();

    // ======================================================================
    // Pin synchronisers, two flops deep
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {config_switch_pairs, fault_lamp_in, fault_optic_in, fault_output_in,
                          mute_s2_in, mute_s1_in, fb_closed_in, start_btn_in, beam_clear_in};
            sync2_reg <= sync1_reg;
        end
    end

    // Synchronised pin names and switch pair decode
    assign {cfg_sw, f_lamp, f_opt, f_out, mute_s2, mute_s1, fb_closed, start_btn,
            beam_clear} = sync2_reg;
    assign {cfg_hi, cfg_lo} = cfg_sw;
    assign cfg_ok    = (cfg_lo == cfg_hi);
    assign to_en     = cfg_lo[`LGS_SW_TIMEOUT];
    assign four_beam = cfg_lo[`LGS_SW_MUTING];
    assign mon_en    = !cfg_lo[`LGS_SW_FEEDBACK];
    assign auto_rst  = cfg_lo[`LGS_SW_RESTART];

    // ======================================================================
    // Millisecond enable divider
    assign ms_wrap = (ms_cnt_reg == `LGS_DIV_W'(MS_DIV - 1));
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_reg  <= '0;
            ms_tick_reg <= 1'b0;
        end else begin
            ms_cnt_reg  <= ms_wrap ? '0 : ms_cnt_reg + `LGS_DIV_W'(1);
            ms_tick_reg <= ms_wrap;
        end
    end

    // ======================================================================
    // Window timers: start hold, sensor pair, muting timeout, feedback
    for (genvar gi = 0; gi < 4; gi++) begin : g_tmr
        assign tmr[gi].tick = ms_tick_reg;
        lgs_timer u_tmr (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .tif     (tmr[gi])
        );
    end

    // Start button held while armed
    assign tmr[0].run   = start_btn && (st_reg == lgs_pkg::LGS_ST_ARM);
    assign tmr[0].limit = `LGS_TMR_W'(`LGS_CNT_START_MS);
    assign start_done   = tmr[0].expired;

    // One sensor active while waiting for the second
    assign tmr[1].run   = s_one && !mute_reg;
    assign tmr[1].limit = `LGS_TMR_W'(`LGS_CNT_PAIR_MS);
    assign pair_exp     = tmr[1].expired;

    // Muting duration, only when the timeout is selected
    assign tmr[2].run   = mute_reg && to_en;
    assign tmr[2].limit = `LGS_TMR_W'(MUTE_TO_MS);
    assign mute_to_exp  = tmr[2].expired;

    // Feedback contact in the wrong state for the present output level
    assign tmr[3].run   = mon_en && (fb_closed == out_on);
    assign tmr[3].limit = out_on ? `LGS_TMR_W'(`LGS_T_FB_OPEN_MS)
                                 : `LGS_TMR_W'(`LGS_T_FB_CLOSE_MS);
    assign fb_err       = tmr[3].expired;
    assign fb_ok        = !mon_en || fb_closed;

    // ======================================================================
    // Error collection; a new fault wins over a clear in the same cycle
    assign err_set  = {!cfg_ok, fb_err, f_lamp, f_opt, f_out};
    assign err_next = (err_reg & ~{`LGS_ERR_W{err_clr}}) | err_set;
    assign err_any  = (|err_reg) || (|err_set);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= '0;
        end else begin
            err_reg <= err_next;
        end
    end

    // ======================================================================
    // Trip conditions
    assign out_on   = safety_output_pair[0];
    assign beam_int = !beam_clear || test_reg;
    assign trip     = (beam_int && !mute_reg) || mute_to_exp;

    // Operating state sequencing
    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            lgs_pkg::LGS_ST_RUN: begin
                if (trip) st_next = lgs_pkg::LGS_ST_TRIP;
            end
            lgs_pkg::LGS_ST_TRIP: begin
                if (!beam_int && fb_ok) begin
                    st_next = auto_rst ? lgs_pkg::LGS_ST_RUN
                                       : lgs_pkg::LGS_ST_ARM;
                end
            end
            lgs_pkg::LGS_ST_ARM: begin
                if (beam_int) st_next = lgs_pkg::LGS_ST_TRIP;
                else if (start_done && fb_ok) st_next = lgs_pkg::LGS_ST_RUN;
            end
            lgs_pkg::LGS_ST_SAFE: begin
                if (!err_any) st_next = lgs_pkg::LGS_ST_TRIP;
            end
            default: st_next = lgs_pkg::LGS_ST_SAFE;
        endcase
        if (err_any) st_next = lgs_pkg::LGS_ST_SAFE;
    end

    // State and output registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg             <= lgs_pkg::LGS_ST_SAFE;
            safety_output_pair <= 2'h0;
            safe_state         <= 1'b1;
            muting_lamp        <= 1'b0;
        end else begin
            st_reg             <= st_next;
            safety_output_pair <= {2{st_next == lgs_pkg::LGS_ST_RUN}};
            safe_state         <= (st_next == lgs_pkg::LGS_ST_SAFE);
            muting_lamp        <= mute_next;
        end
    end

    // ======================================================================
    // Muting entry and exit
    assign s_none    = !mute_s1 && !mute_s2;
    assign s_both    = mute_s1 && mute_s2;
    assign s_one     = mute_s1 ^ mute_s2;
    assign mute_go   = (st_reg == lgs_pkg::LGS_ST_RUN) && s_both && !mute_blk_reg
                       && !pair_exp && (four_beam || !first_s2_reg) && !f_lamp
                       && !mute_to_exp;
    assign mute_next = mute_go || (mute_reg && !s_none && !mute_to_exp &&
                                   (st_reg == lgs_pkg::LGS_ST_RUN));
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mute_reg     <= 1'b0;
            mute_blk_reg <= 1'b0;
            first_s2_reg <= 1'b0;
        end else begin
            mute_reg     <= mute_next;
            mute_blk_reg <= !s_none && (mute_blk_reg || pair_exp || mute_to_exp);
            first_s2_reg <= !s_none && (first_s2_reg || (mute_s2 && !mute_s1 && !mute_reg));
        end
    end

    // ======================================================================
    // AXI4-Lite write path: address and data taken in either order
    assign aw_take     = s_axi_awvalid && s_axi_awready;
    assign w_take      = s_axi_wvalid && s_axi_wready;
    assign wr_go       = (aw_got_reg || aw_take) && (w_got_reg || w_take);
    assign aw_got_next = (aw_got_reg || aw_take) && !wr_go;
    assign w_got_next  = (w_got_reg || w_take) && !wr_go;
    assign bvalid_next = wr_go || (s_axi_bvalid && !s_axi_bready);
    assign wr_addr     = aw_got_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_data     = w_got_reg ? wdata_reg : s_axi_wdata;
    assign wr_strb     = w_got_reg ? wstrb_reg : s_axi_wstrb;
    assign wr_ctrl     = wr_go && (wr_addr == `LGS_ADDR_CTRL);
    assign err_clr     = wr_ctrl && wr_strb[0] && wr_data[`LGS_CTRL_ERR_CLR];

    // Write channel registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LGS_RESP_OKAY;
            test_reg      <= 1'b0;
        end else begin
            aw_got_reg    <= aw_got_next;
            w_got_reg     <= w_got_next;
            if (aw_take) awaddr_reg <= s_axi_awaddr;
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            s_axi_awready <= !aw_got_next && !bvalid_next;
            s_axi_wready  <= !w_got_next && !bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            if (wr_go) s_axi_bresp <= wr_ctrl ? `LGS_RESP_OKAY : `LGS_RESP_SLVERR;
            if (wr_ctrl && wr_strb[0]) test_reg <= wr_data[`LGS_CTRL_TEST];
        end
    end

    // ======================================================================
    // AXI4-Lite read path and register decode
    assign ar_take     = s_axi_arvalid && s_axi_arready;
    assign rvalid_next = ar_take || (s_axi_rvalid && !s_axi_rready);
    assign rd_hit      = (s_axi_araddr == `LGS_ADDR_CTRL) ||
                         (s_axi_araddr == `LGS_ADDR_STATUS) ||
                         (s_axi_araddr == `LGS_ADDR_CONFIG);
    assign rd_word     = (s_axi_araddr == `LGS_ADDR_CTRL)   ? 32'({test_reg, 1'b0}) :
                         (s_axi_araddr == `LGS_ADDR_STATUS) ? 32'({err_reg, fb_closed,
                                                               muting_lamp, out_on, st_reg}) :
                         (s_axi_araddr == `LGS_ADDR_CONFIG) ? 32'(cfg_sw) : 32'h0000_0000;

    // Read channel registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `LGS_RESP_OKAY;
        end else begin
            s_axi_arready <= !rvalid_next;
            s_axi_rvalid  <= rvalid_next;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `LGS_RESP_OKAY : `LGS_RESP_SLVERR;
            end
        end
    end

    // ======================================================================
    // Assertions and covers
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_beam_trip_off: assert property (
        (st_reg == lgs_pkg::LGS_ST_RUN) && beam_int && !mute_reg |=> !out_on && !safety_output_pair[1]
    ) else $error("outputs stayed on after beam interruption");

    a_fault_to_safe: assert property (
        (f_out || f_opt || f_lamp || fb_err) |=> safe_state && !out_on
    ) else $error("internal fault did not reach safe condition");

    a_safe_latched: assert property (
        (st_reg == lgs_pkg::LGS_ST_SAFE) && (|err_reg) && !err_clr
        |=> (st_reg == lgs_pkg::LGS_ST_SAFE) [*2]
    ) else $error("safe condition left without explicit reset");

    a_pair_mismatch: assert property (
        (cfg_lo != cfg_hi) |=> (err_reg[`LGS_ERR_W-1] && safe_state)
    ) else $error("switch pair disagreement not treated as error");

    a_auto_restart: assert property (
        (st_reg == lgs_pkg::LGS_ST_TRIP) && auto_rst && !beam_int && fb_ok && !err_any
        |=> out_on
    ) else $error("automatic restart did not switch outputs on");

    a_start_held: assert property (
        $rose(out_on) && ($past(st_reg) == lgs_pkg::LGS_ST_ARM) |-> $past(start_done && start_btn)
    ) else $error("interlocked restart without start held");

    a_fb_windows: assert property (
        mon_en && (fb_closed == out_on) |->
        (tmr[3].limit == (out_on ? `LGS_TMR_W'(`LGS_T_FB_OPEN_MS)
                                 : `LGS_TMR_W'(`LGS_T_FB_CLOSE_MS)))
    ) else $error("feedback window length wrong");

    a_mute_keeps_on: assert property (
        muting_lamp && mute_reg && beam_int && !test_reg && !mute_to_exp && !err_any && s_both
        |=> out_on
    ) else $error("outputs dropped while muting active");

    a_mute_refused: assert property (
        (st_reg != lgs_pkg::LGS_ST_RUN) |=> !muting_lamp
    ) else $error("muting entered outside normal operation");

    a_mute_timeout: assert property (
        mute_to_exp |=> !muting_lamp && !out_on ##1 !muting_lamp
    ) else $error("muting not cancelled at timeout");

    a_mute_pair_late: assert property (
        $rose(muting_lamp) |-> $past(!pair_exp && !mute_blk_reg)
    ) else $error("muting entered after sensor pair window");

    c_auto_restart: cover property ($rose(out_on) && auto_rst);
    c_arm_restart:  cover property ($rose(out_on) && !auto_rst);
    c_mute_enter:   cover property ($rose(muting_lamp));
    c_safe_enter:   cover property ($rose(safe_state));
endmodule // lgs_safety_ctrl
`default_nettype wire

/* File: lgs_contactor_model.sv */
// Contactor model with a normally closed feedback contact
`timescale 1ns/1ps
`default_nettype none
module lgs_contactor_model (
    input  wire logic       clk_sys,
    input  wire logic [1:0] coil,
    input  wire logic       stuck,
    output logic            fb_closed
);
    logic [4:0] cnt_reg = 5'h00;
    logic       fb_reg  = 1'b1;
    assign fb_closed = fb_reg;
    // Contact follows the coil 20 cycles late unless welded
    always @(posedge clk_sys) begin
        cnt_reg <= (stuck || fb_reg != coil[0]) ? 5'h00 : cnt_reg + 5'h01;
        if (cnt_reg == 5'h13) fb_reg <= ~fb_reg;
    end
endmodule // lgs_contactor_model
`default_nettype wire

/* File: test_light_grid_safety_output_control.sv */
// Self-checking bench for the light grid safety output controller
`timescale 1ns/1ps
`default_nettype none
module test_light_grid_safety_output_control;
    logic        clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, beam_clear_in, start_btn_in, fb_closed_in, mute_s1_in;
    logic        mute_s2_in, fault_output_in, fault_optic_in, fault_lamp_in, stuck;
    logic        muting_lamp, safe_state;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, config_switch_pairs;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, safety_output_pair;
    int          errors = 0;
    int          n_compared = 0;
    // ==========================================================
    // Design and contactor
    lgs_safety_ctrl #(.MS_DIV(10), .MUTE_TO_MS(20)) dut_u (
        .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .beam_clear_in, .start_btn_in, .fb_closed_in,
        .mute_s1_in, .mute_s2_in, .fault_output_in, .fault_optic_in, .fault_lamp_in,
        .config_switch_pairs, .safety_output_pair, .muting_lamp, .safe_state);
    lgs_contactor_model partner_u (.clk_sys, .coil(safety_output_pair), .stuck,
        .fb_closed(fb_closed_in));
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        chk("rdata", e, s_axi_rdata & m);
    endtask
    task automatic wo(input logic [1:0] e, input int lim);
        int n;
        n = 0;
        while (safety_output_pair !== e && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk("outputs", 32'(e), 32'(safety_output_pair));
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_boot;
        rd(8'h0c, 32'hffffffff, 32'h0, 2'h2);
        wr(8'h04, 32'h0, 2'h2);
        rd(8'h08, 32'hff, 32'hff, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        wo(2'b11, 60);
        $display("boot done");
    endtask
    task automatic t_trip;
        beam_clear_in <= 1'b0;
        cy(4);
        chk("trip", 0, 32'(safety_output_pair));
        beam_clear_in <= 1'b1;
        wo(2'b11, 10);
        wr(8'h00, 32'h2, 2'h0);
        wo(2'b00, 6);
        rd(8'h00, 32'h3, 32'h2, 2'h0);
        wr(8'h00, 32'h0, 2'h0);
        wo(2'b11, 10);
        $display("trip done");
    endtask
    task automatic t_mute;
        mute_s1_in <= 1'b1;
        mute_s2_in <= 1'b1;
        cy(6);
        chk("lamp", 1, 32'(muting_lamp));
        beam_clear_in <= 1'b0;
        cy(20);
        chk("muted", 3, 32'(safety_output_pair));
        wo(2'b00, 300);
        mute_s1_in <= 1'b0;
        mute_s2_in <= 1'b0;
        beam_clear_in <= 1'b1;
        wo(2'b11, 30);
        $display("mute done");
    endtask
    task automatic t_fb;
        config_switch_pairs <= 8'hbb;
        beam_clear_in <= 1'b0;
        cy(30);
        stuck <= 1'b1;
        beam_clear_in <= 1'b1;
        wo(2'b11, 60);
        cy(3000);
        chk("no early", 3, 32'(safety_output_pair));
        cy(600);
        chk("fb safe", 1, 32'(safe_state));
        rd(8'h04, 32'h400, 32'h400, 2'h0);
        stuck <= 1'b0;
        wr(8'h00, 32'h1, 2'h0);
        wo(2'b11, 60);
        $display("fb done");
    endtask
    task automatic t_lock;
        config_switch_pairs <= 8'h77;
        beam_clear_in <= 1'b0;
        cy(10);
        beam_clear_in <= 1'b1;
        cy(50);
        chk("armed", 0, 32'(safety_output_pair));
        start_btn_in <= 1'b1;
        cy(4800);
        chk("held", 0, 32'(safety_output_pair));
        wo(2'b11, 400);
        start_btn_in <= 1'b0;
        config_switch_pairs <= 8'hfe;
        cy(10);
        chk("pair", 1, 32'(safe_state));
        rd(8'h04, 32'h800, 32'h800, 2'h0);
        config_switch_pairs <= 8'hff;
        cy(5);
        wr(8'h00, 32'h1, 2'h0);
        wo(2'b11, 60);
        $display("lock done");
    endtask
    task automatic t_fault;
        for (int i = 0; i < 3; i++) begin
            {fault_lamp_in, fault_optic_in, fault_output_in} <= 3'(1 << i);
            cy(4);
            {fault_lamp_in, fault_optic_in, fault_output_in} <= 3'h0;
            rd(8'h04, 32'h398, 32'h8 | (32'h80 << i), 2'h0);
            wr(8'h00, 32'h1, 2'h0);
            wo(2'b11, 60);
        end
        $display("fault done");
    endtask
    task automatic t_two;
        config_switch_pairs <= 8'hdd;
        mute_s2_in <= 1'b1;
        cy(6);
        mute_s1_in <= 1'b1;
        cy(6);
        chk("s2 first", 0, 32'(muting_lamp));
        {mute_s1_in, mute_s2_in} <= 2'b00;
        cy(4);
        mute_s1_in <= 1'b1;
        cy(4);
        mute_s2_in <= 1'b1;
        cy(6);
        chk("s1 first", 1, 32'(muting_lamp));
        {mute_s1_in, mute_s2_in} <= 2'b00;
        config_switch_pairs <= 8'hff;
        cy(4);
        $display("two done");
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {start_btn_in, mute_s1_in, mute_s2_in, stuck, s_axi_awaddr, s_axi_araddr} = '0;
        {fault_output_in, fault_optic_in, fault_lamp_in, s_axi_wdata} = '0;
        {beam_clear_in, config_switch_pairs, s_axi_wstrb} = '1;
        cy(20);
        chk("reset", 1, 32'(safe_state));
        rst_n <= 1'b1;
        cy(1);
        t_boot;
        t_trip;
        t_mute;
        t_fb;
        t_lock;
        t_fault;
        t_two;
        end_sim;
    end
    // Watchdog
    initial begin
        cy(40000);
        errors++;
        end_sim;
    end
endmodule // test_light_grid_safety_output_control
`default_nettype wire
